//--- shared/pief_pkg.sv
package pief_pkg;

    // Word-aligned byte addresses of the three registers on the bus.
    localparam logic [7:0] PIEF_ADDR_ENABLE = 8'h00;
    localparam logic [7:0] PIEF_ADDR_FLAGS  = 8'h04;
    localparam logic [7:0] PIEF_ADDR_CTRL   = 8'h08;

    // Source bit positions, shared by the enable and flag registers.
    localparam int PIEF_BIT_ADC    = 6;
    localparam int PIEF_BIT_CAPCMP = 5;
    localparam int PIEF_BIT_CMP    = 3;
    localparam int PIEF_BIT_TMRB   = 1;
    localparam int PIEF_BIT_TMRA   = 0;

    // Bit positions in the core interrupt control register.
    localparam int PIEF_BIT_GLOBAL_EN = 7;
    localparam int PIEF_BIT_GROUP_EN  = 6;

    // Implemented-bit masks for the two variants and the control register, and the unimplemented-bit mask.
    localparam logic [7:0] PIEF_IMPL_FULL    = 8'h6B;
    localparam logic [7:0] PIEF_IMPL_REDUCED = 8'h09;
    localparam logic [7:0] PIEF_UNIMPL       = 8'h94;
    localparam logic [7:0] PIEF_CTRL_MASK    = 8'hC0;

    localparam logic [7:0]  PIEF_RESET_BYTE = 8'h00;
    localparam logic [23:0] PIEF_PAD_ZERO   = 24'h000000;

    typedef enum logic [1:0] {
        PIEF_CC_OFF     = 2'b00,
        PIEF_CC_CAPTURE = 2'b01,
        PIEF_CC_COMPARE = 2'b10,
        PIEF_CC_PWM     = 2'b11
    } pief_ccmode_t;

endpackage : pief_pkg

//--- core/pief_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: No peripheral request reaches the core while the group enable is clear.
// R2: Enable bits: ADC 6, capture/compare 5, comparator 3, timer B 1, timer A 0.
// R3: Bits 7, 4 and 2 of enable and flags read zero, ignore writes.
// R4: A flag sets on its event regardless of any enable bit.
// R5: Software should clear a flag before enabling its source.
// R6: ADC flag at bit 6 sets when a conversion completes.
// R7: Capture/compare flag sets on capture or compare per mode, unused in PWM.
// R8: Comparator flag at bit 3 sets on any comparator output change, sticky; changes within the first three edges after reset are lost.
// R9: Timer B flag at bit 1 sets on period match, sticky.
// R10: Timer A flag at bit 0 sets on overflow, sticky.
// R11: Implemented enable and flag bits are read/write and reset to zero.
// R12: Reduced variant leaves ADC, capture/compare, timer B bits unimplemented.
// R13: Global enable clear blocks every interrupt; set passes unmasked ones.
// R14: Group enable clear blocks every peripheral interrupt.
// R15: Request asserts with global, group and an enabled set flag together.
module pief_top
    import pief_pkg::*;
#(
    parameter bit FULL_VARIANT = 1'b1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_psel,
    input  wire logic         i_penable,
    input  wire logic         i_pwrite,
    input  wire logic [7:0]   i_paddr,
    input  wire logic [31:0]  i_pwdata,
    output logic      [31:0]  o_prdata,
    output logic              o_pready,
    output logic              o_pslverr,
    input  wire logic         i_adc_done,
    input  wire logic         i_capture_event,
    input  wire logic         i_compare_match,
    input  wire logic [1:0]   i_capcmp_mode,
    input  wire logic         i_comparator_out,
    input  wire logic         i_timer_b_match,
    input  wire logic         i_timer_a_overflow,
    output logic              o_irq
);

    logic [7:0] enable;
    logic [7:0] flags;
    logic [7:0] ctrl;
    logic       cmp_meta;
    logic       cmp_sync;
    logic       cmp_last;
    logic       cmp_primed;
    logic [1:0] cmp_prime_pipe;

    logic [7:0] set_vec;
    logic [7:0] next_enable;
    logic [7:0] next_flags;
    logic [7:0] next_ctrl;
    logic       next_irq;
    logic       next_pready;
    logic       next_pslverr;
    logic [31:0] next_prdata;

    wire [7:0] impl = FULL_VARIANT ? PIEF_IMPL_FULL : PIEF_IMPL_REDUCED; // R3 R12

    // Bus decode: one wait state, the answer comes in the second access cycle.
    wire       access = i_psel & i_penable;
    wire       done   = access & o_pready;
    wire       hit_en = i_paddr == PIEF_ADDR_ENABLE;
    wire       hit_fl = i_paddr == PIEF_ADDR_FLAGS;
    wire       hit_ct = i_paddr == PIEF_ADDR_CTRL;
    wire       hit    = hit_en | hit_fl | hit_ct;
    wire       wr_en  = done & i_pwrite & hit_en;
    wire       wr_fl  = done & i_pwrite & hit_fl;
    wire       wr_ct  = done & i_pwrite & hit_ct;
    wire [7:0] wbyte  = i_pwdata[7:0];

    wire [7:0] rd_byte = hit_en ? enable :
                         hit_fl ? flags  :
                         hit_ct ? ctrl   : PIEF_RESET_BYTE;

    // Capture/compare events count only in the mode that owns them.
    wire cc_capture = i_capture_event &
                      (pief_ccmode_t'(i_capcmp_mode) == PIEF_CC_CAPTURE); // R7
    wire cc_compare = i_compare_match &
                      (pief_ccmode_t'(i_capcmp_mode) == PIEF_CC_COMPARE); // R7

    // The edge detector stays blind for three edges after reset, until the last-value
    // flop holds a real pin sample, so a comparator idling high raises no false event.
    // A genuine change inside that window is lost, which is the price of that guard.
    wire cmp_change = cmp_primed & (cmp_sync ^ cmp_last); // R8

    always_comb begin
        set_vec                  = PIEF_RESET_BYTE;
        set_vec[PIEF_BIT_ADC]    = i_adc_done; // R6
        set_vec[PIEF_BIT_CAPCMP] = cc_capture | cc_compare; // R7
        set_vec[PIEF_BIT_CMP]    = cmp_change; // R8
        set_vec[PIEF_BIT_TMRB]   = i_timer_b_match; // R9
        set_vec[PIEF_BIT_TMRA]   = i_timer_a_overflow; // R10
    end

    wire [7:0] set_hit = set_vec & impl;

    // Hardware set wins over a software write of zero in the same cycle.
    assign next_flags  = ((wr_fl ? wbyte : flags) | set_vec) & impl; // R4
    assign next_enable = wr_en ? (wbyte & impl) : enable; // R2
    assign next_ctrl   = wr_ct ? (wbyte & PIEF_CTRL_MASK) : ctrl;

    assign next_irq = next_ctrl[PIEF_BIT_GLOBAL_EN] // R13
                    & next_ctrl[PIEF_BIT_GROUP_EN] // R1 R14
                    & (|(next_flags & next_enable)); // R15

    assign next_pready  = access & ~o_pready;
    assign next_pslverr = access & ~o_pready & ~hit;
    assign next_prdata  = (access & ~o_pready) ? {PIEF_PAD_ZERO, rd_byte}
                                               : {PIEF_PAD_ZERO, PIEF_RESET_BYTE};

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            enable <= PIEF_RESET_BYTE; // R11
            flags  <= PIEF_RESET_BYTE; // R11
            ctrl   <= PIEF_RESET_BYTE;
        end else begin
            enable <= next_enable;
            flags  <= next_flags;
            ctrl   <= next_ctrl;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cmp_meta   <= 1'b0;
            cmp_sync   <= 1'b0;
            cmp_last   <= 1'b0;
            cmp_primed <= 1'b0;
            cmp_prime_pipe <= '0;
        end else begin
            cmp_meta   <= i_comparator_out;
            cmp_sync   <= cmp_meta;
            cmp_last   <= cmp_sync;
            cmp_prime_pipe <= {cmp_prime_pipe[0], 1'b1};
            cmp_primed <= cmp_prime_pipe[1]; // R8
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_prdata  <= {PIEF_PAD_ZERO, PIEF_RESET_BYTE};
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_irq     <= 1'b0;
        end else begin
            o_prdata  <= next_prdata;
            o_pready  <= next_pready;
            o_pslverr <= next_pslverr;
            o_irq     <= next_irq;
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);

    group_gate_a: assert property ( // R1
        !ctrl[PIEF_BIT_GROUP_EN] |-> !o_irq)
        else $error("Request raised with group enable clear.");

    group_block_a: assert property ( // R14
        $fell(ctrl[PIEF_BIT_GROUP_EN]) |-> !o_irq)
        else $error("Request survived group enable clear.");

    global_gate_a: assert property ( // R13
        !ctrl[PIEF_BIT_GLOBAL_EN] |-> !o_irq)
        else $error("Request raised with global enable clear.");

    irq_request_a: assert property ( // R15
        (ctrl[PIEF_BIT_GLOBAL_EN] && ctrl[PIEF_BIT_GROUP_EN]
         && (|(flags & enable))) |-> o_irq)
        else $error("Enabled flag set but no request.");

    unimpl_zero_a: assert property ( // R3
        ((enable | flags) & PIEF_UNIMPL) == PIEF_RESET_BYTE)
        else $error("Unimplemented bit held a one.");

    reduced_zero_a: assert property ( // R12
        ((enable | flags) & ~impl) == PIEF_RESET_BYTE)
        else $error("Absent source bit held a one.");

    flag_set_a: assert property ( // R4
        (|set_hit) |=> ((flags & $past(set_hit)) == $past(set_hit)))
        else $error("Source event did not set its flag.");

    cmp_change_a: assert property ( // R8
        (cmp_primed && $changed(cmp_sync)) |=> flags[PIEF_BIT_CMP])
        else $error("Comparator change did not set its flag.");

    flag_hold_a: assert property ( // R10
        !wr_fl |=> ((flags & $past(flags)) == $past(flags)))
        else $error("Flag cleared without a software write.");

    enable_write_a: assert property ( // R2
        wr_en |=> (enable == ($past(wbyte) & impl)))
        else $error("Enable write not stored.");

    apb_wait_a: assert property (
        (access && !o_pready) |=> o_pready ##1 !o_pready)
        else $error("Bus answer not given after one wait state.");

    adc_set_a: assert property ( // R6
        (i_adc_done && impl[PIEF_BIT_ADC])
        |=> flags[PIEF_BIT_ADC])
        else $error("Conversion done did not set its flag.");

    adc_quiet_a: assert property ( // R6
        (!i_adc_done && !wr_fl && !flags[PIEF_BIT_ADC])
        |=> !flags[PIEF_BIT_ADC])
        else $error("Conversion flag rose with no conversion.");

    capture_set_a: assert property ( // R7
        (i_capture_event && (i_capcmp_mode == PIEF_CC_CAPTURE) && impl[PIEF_BIT_CAPCMP])
        |=> flags[PIEF_BIT_CAPCMP])
        else $error("Capture did not set its flag.");

    compare_set_a: assert property ( // R7
        (i_compare_match && (i_capcmp_mode == PIEF_CC_COMPARE) && impl[PIEF_BIT_CAPCMP])
        |=> flags[PIEF_BIT_CAPCMP])
        else $error("Compare match did not set its flag.");

    capcmp_idle_a: assert property ( // R7
        (!flags[PIEF_BIT_CAPCMP] && !wr_fl
         && (i_capcmp_mode inside {PIEF_CC_OFF, PIEF_CC_PWM}))
        |=> !flags[PIEF_BIT_CAPCMP])
        else $error("Capture or compare flag rose while unused.");

    capcmp_cross_a: assert property ( // R7
        (!flags[PIEF_BIT_CAPCMP] && !wr_fl && !i_compare_match
         && (i_capcmp_mode == PIEF_CC_COMPARE))
        |=> !flags[PIEF_BIT_CAPCMP])
        else $error("Capture event counted in compare mode.");

    timer_b_set_a: assert property ( // R9
        (i_timer_b_match && impl[PIEF_BIT_TMRB])
        |=> flags[PIEF_BIT_TMRB])
        else $error("Period match did not set its flag.");

    timer_a_set_a: assert property ( // R10
        i_timer_a_overflow
        |=> flags[PIEF_BIT_TMRA])
        else $error("Overflow did not set its flag.");

    cmp_quiet_a: assert property ( // R8
        (!wr_fl && !flags[PIEF_BIT_CMP] && (cmp_sync == cmp_last))
        |=> !flags[PIEF_BIT_CMP])
        else $error("Comparator flag rose with no change.");

    flag_write_a: assert property ( // R11
        (wr_fl && (set_hit == PIEF_RESET_BYTE))
        |=> (flags == ($past(wbyte) & impl)))
        else $error("Flag write not stored.");

    enable_hold_a: assert property ( // R11
        !wr_en
        |=> $stable(enable))
        else $error("Enable changed without a write.");

    ctrl_write_a: assert property ( // R13
        wr_ct
        |=> (ctrl == ($past(wbyte) & PIEF_CTRL_MASK)))
        else $error("Control write not stored.");

    ctrl_hold_a: assert property ( // R14
        !wr_ct
        |=> $stable(ctrl))
        else $error("Control changed without a write.");

    irq_quiet_a: assert property ( // R15
        !(ctrl[PIEF_BIT_GLOBAL_EN] && ctrl[PIEF_BIT_GROUP_EN] && (|(flags & enable)))
        |-> !o_irq)
        else $error("Request raised with no enabled flag.");

    enable_gate_a: assert property ( // R2
        ((flags & enable) == PIEF_RESET_BYTE)
        |-> !o_irq)
        else $error("Request raised by a disabled source.");

    rdata_idle_a: assert property (
        !o_pready
        |-> (o_prdata == {PIEF_PAD_ZERO, PIEF_RESET_BYTE}))
        else $error("Read data driven outside an answer.");

    rdata_unimpl_a: assert property ( // R3
        (o_pready && !hit_ct)
        |-> ((o_prdata & ~{PIEF_PAD_ZERO, ~PIEF_UNIMPL}) == {PIEF_PAD_ZERO, PIEF_RESET_BYTE}))
        else $error("Read returned a one in an unimplemented bit.");

    slverr_map_a: assert property (
        (access && o_pready)
        |-> (o_pslverr == !hit))
        else $error("Error response does not match the address map.");

    pready_idle_a: assert property (
        !access
        |-> !o_pready)
        else $error("Answer given with no access.");

    slverr_idle_a: assert property (
        !o_pready
        |-> !o_pslverr)
        else $error("Error response outside an answer.");

    pready_pulse_a: assert property (
        o_pready
        |=> !o_pready)
        else $error("Answer stood longer than one cycle.");

endmodule : pief_top

//--- verification/pief_evt_src.sv
`timescale 1ns/1ps
// Far-side event sources: each request bit gives one clean pulse from a flop.
// Bit 5 toggles the comparator level instead, since any change is an event.
// The level idles high so that a level held through reset is seen to raise nothing.
module pief_evt_src (
    input  wire logic       i_clk,
    input  wire logic [5:0] i_req,
    output logic      [4:0] o_pulse,
    output logic            o_cmp_level
);
    initial o_pulse = 5'h00;
    initial o_cmp_level = 1'b1;
    always @(posedge i_clk) begin
        o_pulse <= i_req[4:0];
        o_cmp_level <= o_cmp_level ^ i_req[5];
    end
endmodule : pief_evt_src

//--- verification/peripheral_irq_enable_flags_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module peripheral_irq_enable_flags_tb;
    import pief_pkg::*;
    logic        clk, rst, psel, pen, pwr, pready, perr, irq, cmp, irq_r, err_q;
    logic [7:0]  paddr, v, e, f, c;
    logic [31:0] pwdata, prdata, prdata_r, q, q_r;
    logic [5:0]  req;
    logic [4:0]  pulse;
    logic [1:0]  mode;
    int          errors, tests_run;
    int          bitpos [6] = '{PIEF_BIT_TMRA, PIEF_BIT_TMRB, PIEF_BIT_CAPCMP,
                                PIEF_BIT_CAPCMP, PIEF_BIT_ADC, PIEF_BIT_CMP};
    pief_evt_src src_u (.i_clk(clk), .i_req(req), .o_pulse(pulse), .o_cmp_level(cmp));
    pief_top dut_u (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(perr), .i_adc_done(pulse[4]),
        .i_capture_event(pulse[2]), .i_compare_match(pulse[3]), .i_capcmp_mode(mode),
        .i_comparator_out(cmp), .i_timer_b_match(pulse[1]),
        .i_timer_a_overflow(pulse[0]), .o_irq(irq));
    pief_top #(.FULL_VARIANT(1'b0)) red_u (.i_clk(clk), .i_rst(rst), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata_r), .o_pready(), .o_pslverr(), .i_adc_done(pulse[4]),
        .i_capture_event(pulse[2]), .i_compare_match(pulse[3]), .i_capcmp_mode(mode),
        .i_comparator_out(cmp), .i_timer_b_match(pulse[1]),
        .i_timer_a_overflow(pulse[0]), .o_irq(irq_r));
    function automatic logic exp_irq(input logic [7:0] cc, ee, ff, mm);
        return cc[PIEF_BIT_GLOBAL_EN] & cc[PIEF_BIT_GROUP_EN] & |(ee & ff & mm);
    endfunction : exp_irq
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= {PIEF_PAD_ZERO, d};
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
        q = prdata;
        q_r = prdata_r;
        err_q = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (n >= 20) begin
            errors++;
            complete_run();
        end
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [7:0] ex);
        bus(1'b0, a, 8'h00);
        `CHK(q, {PIEF_PAD_ZERO, ex})
    endtask : rd
    // Waiting one edge lets the write's own edge land before the level is read.
    task automatic chk_irq(input logic ex);
        @(posedge clk);
        `CHK(irq, ex)
    endtask : chk_irq
    task automatic fire(input int k);
        @(posedge clk);
        req <= 6'h01 << k;
        @(posedge clk);
        req <= 6'h00;
        repeat (6) @(posedge clk);
    endtask : fire
    task automatic complete_run;
        if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        complete_run();
    end
    initial begin
        rst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; req = 6'h00; mode = PIEF_CC_CAPTURE; errors = 0; tests_run = 0;
        void'($urandom(32'hB2695941));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(PIEF_ADDR_ENABLE, 8'h00);
        rd(PIEF_ADDR_FLAGS, 8'h00);
        rd(8'h0C, 8'h00);
        `CHK(err_q, 1'b1)
        bus(1'b1, PIEF_ADDR_CTRL, PIEF_CTRL_MASK);
        for (int k = 0; k < 6; k++) begin
            mode <= (k == 3) ? PIEF_CC_COMPARE : PIEF_CC_CAPTURE;
            bus(1'b1, PIEF_ADDR_ENABLE, 8'h00);
            fire(k);
            rd(PIEF_ADDR_FLAGS, 8'h01 << bitpos[k]);
            `CHK(q_r[7:0], PIEF_IMPL_REDUCED & (8'h01 << bitpos[k]))
            chk_irq(1'b0);
            bus(1'b1, PIEF_ADDR_ENABLE, 8'h01 << bitpos[k]);
            chk_irq(1'b1);
            bus(1'b1, PIEF_ADDR_FLAGS, 8'h00);
            chk_irq(1'b0);
        end
        for (int m = 0; m < 4; m += 3) begin
            mode <= pief_ccmode_t'(m);
            fire(2);
            fire(3);
            rd(PIEF_ADDR_FLAGS, 8'h00);
        end
        repeat (24) begin
            e = $urandom; f = $urandom; c = $urandom;
            bus(1'b1, PIEF_ADDR_ENABLE, e);
            bus(1'b1, PIEF_ADDR_FLAGS, f);
            bus(1'b1, PIEF_ADDR_CTRL, c);
            chk_irq(exp_irq(c, e, f, PIEF_IMPL_FULL));
            `CHK(irq_r, exp_irq(c, e, f, PIEF_IMPL_REDUCED))
            rd(PIEF_ADDR_ENABLE, e & PIEF_IMPL_FULL);
            `CHK(q_r[7:0], e & PIEF_IMPL_REDUCED)
            `CHK(err_q, 1'b0)
            rd(PIEF_ADDR_FLAGS, f & PIEF_IMPL_FULL);
        end
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        `CHK(irq, 1'b0)
        rd(PIEF_ADDR_ENABLE, 8'h00);
        rd(PIEF_ADDR_FLAGS, 8'h00);
        rd(PIEF_ADDR_CTRL, 8'h00);
        complete_run();
    end
endmodule : peripheral_irq_enable_flags_tb
